// ==== cmp_pkg.sv ====
// shared constants and types for the core memory port control pair
package cmp_pkg;
   // ==========================================================
   // widths and fields
   localparam int NPORT    = 4;
   localparam int DATA_W   = 36;
   localparam int WORD_W   = 37;
   localparam int ADDR_W   = 24;
   localparam int UNIT_LSB = 18;
   localparam int UNIT_W   = 4;
   localparam int CYC_LSB  = 22;
   localparam int WORDS_BIG   = 16384;
   localparam int WORDS_SMALL = 8192;
   // ==========================================================
   // timing
   localparam int CLK_NS   = 50;
   localparam int CYCLE_NS = 930;
   localparam int READ_NS  = 550;
   localparam int ACK_NS   = 200;
   // longest times round down
   localparam logic [4:0] CYCLE_CYC = 5'(CYCLE_NS / CLK_NS);
   localparam logic [4:0] READ_CYC  = 5'(READ_NS / CLK_NS);
   localparam logic [4:0] ACK_CYC   = 5'(ACK_NS / CLK_NS);
   // ==========================================================
   // cycle type carried on the address lines
   typedef enum logic [1:0] {
      CYC_NONE = 2'h0,
      CYC_RD   = 2'h1,
      CYC_WR   = 2'h2,
      CYC_RMW  = 2'h3
   } cmp_cyc_t;
   typedef enum logic [2:0] {PH_IDLE, PH_READ, PH_WAITW, PH_WRITE, PH_DONE} cmp_phase_t;
   typedef enum logic [2:0] {RQ_IDLE, RQ_REQ, RQ_WAITD, RQ_WAITM, RQ_FIN} cmp_rq_t;
endpackage : cmp_pkg

// ==== cmp_bus_if.sv ====
// memory bus between up to four requesters and one memory unit
`timescale 1ns/1ns
`default_nettype none
interface cmp_bus_if;
   import cmp_pkg::*;
   wire [NPORT-1:0]  req;
   wire [ADDR_W-1:0] memory_address_lines [NPORT];
   wire [DATA_W-1:0] wdata [NPORT];
   wire [NPORT-1:0]  wpar;
   wire [NPORT-1:0]  wstb;
   wire [NPORT-1:0]  ack;
   wire [NPORT-1:0]  rstb;
   wire [NPORT-1:0]  parity_ignore_pulse;
   wire [DATA_W-1:0] rdata;
   wire              rpar;

   modport mem_mp (input req, memory_address_lines, wdata, wpar, wstb,
                   output ack, rstb, parity_ignore_pulse, rdata, rpar);
   modport req_mp (output req, memory_address_lines, wdata, wpar, wstb,
                   input ack, rstb, parity_ignore_pulse, rdata, rpar);
endinterface : cmp_bus_if
`default_nettype wire

// ==== cmp_mem_unit.sv ====
// memory unit end: port arbitration, cycle control, word buffer and store
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - requester asks, unit answers; no fixed timing
// - answer only when address unit field matches switches
// - four ports, one requester each
// - priority network orders simultaneous port requests
// - interleave switch alternates consecutive words between pair
// - requester sends odd parity with write data
// - parity stored unchecked, returned on read
// - no parity storage: ignore pulse with acknowledge
// - address lines carry location and cycle type
// - write data latched into buffer, then stored
// - read word restored from buffer afterwards
// - read data strobed to bus and buffer together
// - ones get word and digit drive; zeros word only
// - words are 36 data bits plus parity
// - capacity 16384 or 8192 words
// - whole cycle within 930 ns except rmw, which adds the requester's pause
// - read data within 550 ns of acceptance
module cmp_mem_unit #(
   parameter int WORDS = cmp_pkg::WORDS_BIG
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   cmp_bus_if.mem_mp                   bus,
   input  wire logic [cmp_pkg::UNIT_W-1:0] unit_sw,
   input  wire logic                   ilv_en,
   input  wire logic                   par_avail,
   output logic                        busy,
   output logic                        word_drive,
   output logic [cmp_pkg::WORD_W-1:0]  digit_drive
);
   import cmp_pkg::*;

   localparam int LOCW = $clog2(WORDS);

   // ==========================================================
   // state
   typedef struct packed {
      cmp_phase_t        phase;
      logic [1:0]        port;
      logic [4:0]        cnt;
      cmp_cyc_t          cyc;
      logic [LOCW-1:0]   loc;
      logic [WORD_W-1:0] wbuf;
      logic [NPORT-1:0]  ack;
      logic [NPORT-1:0]  rstb;
      logic [NPORT-1:0]  pign;
      logic [DATA_W-1:0] rdata;
      logic              rpar;
      logic              word_drv;
      logic [WORD_W-1:0] digit_drv;
      logic              busy;
      logic [UNIT_W+1:0] pin_s1;
      logic [UNIT_W+1:0] pin_s2;
   } cmp_unit_st_t;

   cmp_unit_st_t st_reg;
   cmp_unit_st_t st_next;

   // switches are pins: two flops each before any decode reads them
   logic [UNIT_W-1:0] sw_q;
   logic              ilv_q;
   logic              par_q;

   assign sw_q  = st_reg.pin_s2[UNIT_W-1:0];
   assign ilv_q = st_reg.pin_s2[UNIT_W];
   assign par_q = st_reg.pin_s2[UNIT_W+1];

   // core store, no reset: contents survive a reset like the real stack
   logic [WORD_W-1:0] core_mem [WORDS];
   logic [WORD_W-1:0] sensed;

   // ==========================================================
   // decode helpers
   function automatic logic unit_hit(input logic [ADDR_W-1:0] a,
                                     input logic [UNIT_W-1:0] sw,
                                     input logic              ilv);
      logic [UNIT_W-1:0] u;
      u = a[UNIT_LSB +: UNIT_W];
      if (ilv)
         return (u[UNIT_W-1:1] == sw[UNIT_W-1:1]) && (a[0] == sw[0]);
      return u == sw;
   endfunction : unit_hit

   function automatic logic [LOCW-1:0] word_index(input logic [ADDR_W-1:0] a,
                                                 input logic              ilv);
      // in interleave the low address bit picks the unit, so the unit
      // field's low bit takes its place in the word index
      if (ilv)
         return {a[UNIT_LSB], a[LOCW-1:1]};
      return a[LOCW-1:0];
   endfunction : word_index

   function automatic cmp_cyc_t cyc_of(input logic [ADDR_W-1:0] a);
      return cmp_cyc_t'(a[CYC_LSB +: 2]);
   endfunction : cyc_of

   function automatic logic [1:0] pick(input logic [NPORT-1:0] h);
      logic [1:0] g;
      g = 2'h0;
      for (int i = NPORT - 1; i >= 0; i--) begin
         if (h[i]) begin
            g = 2'(i);
         end
      end
      return g;
   endfunction : pick

   // ==========================================================
   // port request qualification
   logic [NPORT-1:0] hits;

   always_comb begin
      for (int i = 0; i < NPORT; i++) begin
         // each port belongs to one requester and is judged alone
         hits[i] = bus.req[i] && unit_hit(bus.memory_address_lines[i], sw_q, ilv_q)
                   && (cyc_of(bus.memory_address_lines[i]) != CYC_NONE);
      end
   end

   assign sensed = core_mem[st_reg.loc];

   // ==========================================================
   // cycle control
   always_comb begin
      logic [1:0] g;
      g = pick(hits);
      st_next = st_reg;
      st_next.ack = '0;
      st_next.rstb = '0;
      st_next.pign = '0;
      st_next.word_drv = 1'b0;
      st_next.digit_drv = '0;
      st_next.cnt = st_reg.cnt + 5'h1;
      st_next.pin_s1 = {par_avail, ilv_en, unit_sw};
      st_next.pin_s2 = st_reg.pin_s1;
      unique case (st_reg.phase)
         PH_IDLE: begin
            st_next.cnt = 5'h0;
            st_next.busy = 1'b0;
            if (|hits) begin
               st_next.phase = PH_READ;
               st_next.port = g;
               st_next.cnt = 5'h1;
               st_next.busy = 1'b1;
               st_next.cyc = cyc_of(bus.memory_address_lines[g]);
               st_next.loc = word_index(bus.memory_address_lines[g], ilv_q);
               st_next.ack[g] = 1'b1;
               st_next.pign[g] = ~par_q;
               if (cyc_of(bus.memory_address_lines[g]) == CYC_WR) begin
                  st_next.wbuf = {bus.wpar[g], bus.wdata[g]};
               end
            end
         end
         PH_READ: begin
            if (st_reg.cnt == READ_CYC - 5'h1) begin
               if (st_reg.cyc != CYC_WR) begin
                  st_next.rdata = sensed[DATA_W-1:0];
                  st_next.rpar = sensed[WORD_W-1];
                  st_next.rstb[st_reg.port] = 1'b1;
                  st_next.wbuf = sensed;
               end
               st_next.phase = (st_reg.cyc == CYC_RMW) ? PH_WAITW : PH_WRITE;
            end
         end
         PH_WAITW: begin
            // timer frozen here: the requester owns the pause
            st_next.cnt = st_reg.cnt;
            if (bus.wstb[st_reg.port]) begin
               st_next.wbuf = {bus.wpar[st_reg.port], bus.wdata[st_reg.port]};
               st_next.phase = PH_WRITE;
            end
         end
         PH_WRITE: begin
            st_next.word_drv = 1'b1;
            st_next.digit_drv = st_reg.wbuf;
            st_next.phase = PH_DONE;
         end
         PH_DONE: begin
            if (st_reg.cnt >= CYCLE_CYC - 5'h1) begin
               st_next.phase = PH_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // stack write: a bit with no digit drive stays zero
   always_ff @(posedge core_clk) begin
      if (st_reg.word_drv) begin
         core_mem[st_reg.loc] <= st_reg.digit_drv;
      end
   end

   // ==========================================================
   // outputs
   assign bus.ack = st_reg.ack;
   assign bus.rstb = st_reg.rstb;
   assign bus.parity_ignore_pulse = st_reg.pign;
   assign bus.rdata = st_reg.rdata;
   assign bus.rpar = st_reg.rpar;
   assign busy = st_reg.busy;
   assign word_drive = st_reg.word_drv;
   assign digit_drive = st_reg.digit_drv;
endmodule : cmp_mem_unit
`default_nettype wire

// ==== cmp_requester.sv ====
// requester end: one processor or channel on one port of the memory bus
`timescale 1ns/1ns
`default_nettype none
module cmp_requester #(
   parameter int PORT = 0
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst_b,
   cmp_bus_if.req_mp                   bus,
   input  wire logic                   cmd_valid,
   output logic                        cmd_ready,
   input  wire cmp_pkg::cmp_cyc_t      cmd_cyc,
   input  wire logic [cmp_pkg::CYC_LSB-1:0] cmd_addr,
   input  wire logic [cmp_pkg::DATA_W-1:0]  cmd_wdata,
   input  wire logic                   mod_valid,
   input  wire logic [cmp_pkg::DATA_W-1:0]  mod_data,
   output logic                        rsp_valid,
   output logic [cmp_pkg::DATA_W-1:0]  rsp_data,
   output logic                        rsp_par,
   output logic                        par_ign,
   output logic                        done
);
   import cmp_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      cmp_rq_t           phase;
      cmp_cyc_t          cyc;
      logic              req;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wpar;
      logic              wstb;
      logic              ready;
      logic              rsp_valid;
      logic [DATA_W-1:0] rsp_data;
      logic              rsp_par;
      logic              par_ign;
      logic              done;
   } cmp_rq_st_t;

   cmp_rq_st_t st_reg;
   cmp_rq_st_t st_next;

   // ==========================================================
   // sequence
   always_comb begin
      st_next = st_reg;
      st_next.rsp_valid = 1'b0;
      st_next.par_ign = 1'b0;
      st_next.done = 1'b0;
      st_next.wstb = 1'b0;
      unique case (st_reg.phase)
         RQ_IDLE: begin
            st_next.ready = 1'b1;
            if (cmd_valid) begin
               st_next.req = 1'b1;
               st_next.cyc = cmd_cyc;
               st_next.addr = {cmd_cyc, cmd_addr};
               st_next.wdata = cmd_wdata;
               st_next.wpar = ~^cmd_wdata;
               st_next.ready = 1'b0;
               st_next.phase = RQ_REQ;
            end
         end
         RQ_REQ: begin
            // request held until the unit answers, however long
            if (bus.ack[PORT]) begin
               st_next.req = 1'b0;
               st_next.par_ign = bus.parity_ignore_pulse[PORT];
               if (st_reg.cyc == CYC_WR) begin
                  st_next.done = 1'b1;
                  st_next.ready = 1'b1;
                  st_next.phase = RQ_IDLE;
               end else begin
                  st_next.phase = RQ_WAITD;
               end
            end
         end
         RQ_WAITD: begin
            if (bus.rstb[PORT]) begin
               st_next.rsp_valid = 1'b1;
               st_next.rsp_data = bus.rdata;
               st_next.rsp_par = bus.rpar;
               if (st_reg.cyc == CYC_RMW) begin
                  st_next.phase = RQ_WAITM;
               end else begin
                  st_next.done = 1'b1;
                  st_next.ready = 1'b1;
                  st_next.phase = RQ_IDLE;
               end
            end
         end
         RQ_WAITM: begin
            if (mod_valid) begin
               st_next.wdata = mod_data;
               st_next.wpar = ~^mod_data;
               st_next.wstb = 1'b1;
               st_next.phase = RQ_FIN;
            end
         end
         RQ_FIN: begin
            st_next.done = 1'b1;
            st_next.ready = 1'b1;
            st_next.phase = RQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs
   assign bus.req[PORT] = st_reg.req;
   assign bus.memory_address_lines[PORT] = st_reg.addr;
   assign bus.wdata[PORT] = st_reg.wdata;
   assign bus.wpar[PORT] = st_reg.wpar;
   assign bus.wstb[PORT] = st_reg.wstb;
   assign cmd_ready = st_reg.ready;
   assign rsp_valid = st_reg.rsp_valid;
   assign rsp_data = st_reg.rsp_data;
   assign rsp_par = st_reg.rsp_par;
   assign par_ign = st_reg.par_ign;
   assign done = st_reg.done;
endmodule : cmp_requester
`default_nettype wire

// ==== cmp_bus_chk.sv ====
// assertions on the memory bus between the requesters and the memory unit
`timescale 1ns/1ns
`default_nettype none
module cmp_bus_chk (
   input wire logic                       core_clk,
   input wire logic                       rst_b,
   input wire logic [cmp_pkg::NPORT-1:0]  req,
   input wire logic [cmp_pkg::ADDR_W-1:0] memory_address_lines [cmp_pkg::NPORT],
   input wire logic [cmp_pkg::DATA_W-1:0] wdata [cmp_pkg::NPORT],
   input wire logic [cmp_pkg::NPORT-1:0]  wpar,
   input wire logic [cmp_pkg::NPORT-1:0]  wstb,
   input wire logic [cmp_pkg::NPORT-1:0]  ack,
   input wire logic [cmp_pkg::NPORT-1:0]  rstb,
   input wire logic [cmp_pkg::NPORT-1:0]  parity_ignore_pulse,
   input wire logic [cmp_pkg::DATA_W-1:0] rdata,
   input wire logic                       rpar,
   input wire logic [cmp_pkg::UNIT_W-1:0] unit_sw,
   input wire logic                       ilv_en,
   input wire logic                       par_avail
);
   import cmp_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // helper state: cycles since last grant, pending rmw
   logic [4:0] gap_reg;
   logic [1:0] cyc_reg;
   logic       hold_reg;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gap_reg  <= 5'h1F;
         cyc_reg  <= 2'h0;
         hold_reg <= 1'b0;
      end else begin
         // saturates so a long idle never wraps into a false gap
         if (|ack) gap_reg <= 5'h01;
         else if (gap_reg != 5'h1F) gap_reg <= gap_reg + 5'h01;
         for (int i = 0; i < NPORT; i++) begin
            if (ack[i]) cyc_reg <= memory_address_lines[i][23:22];
         end
         if (|rstb && cyc_reg == CYC_RMW) hold_reg <= 1'b1;
         else if (|wstb) hold_reg <= 1'b0;
      end
   end
   // ==========================================================
   // unit wide
   a_one_grant: assert property ($onehot0(ack)) else $error("two ports granted");
   a_cycle_gap: assert property (|ack |-> gap_reg >= 5'h12) else $error("grant too soon");
   a_rmw_hold: assert property (hold_reg |-> ack == 4'h0) else $error("grant in rmw wait");
   a_rdata_hold: assert property ($changed(rdata) |-> |rstb) else $error("rdata moved");
   a_rpar_odd: assert property (|rstb |-> rpar == ~^rdata) else $error("parity lost");
   // ==========================================================
   // per port
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      wire [1:0] cyc = memory_address_lines[p][23:22];
      wire [3:0] sel = ilv_en ? {memory_address_lines[p][21:19], memory_address_lines[p][0]}
                              : memory_address_lines[p][21:18];
      sequence s_fetch;
         ack[p] && cyc[0];
      endsequence
      sequence s_store;
         ack[p] && cyc == CYC_WR;
      endsequence
      a_ack_on_req: assert property (ack[p] |-> req[p] ##1 !ack[p]) else $error("bad ack");
      a_unit_match: assert property (ack[p] |-> sel == unit_sw) else $error("wrong unit");
      a_pign_ack: assert property (parity_ignore_pulse[p] == (ack[p] && !par_avail))
         else $error("parity ignore misplaced");
      a_fetch_strobe: assert property (s_fetch |-> ##10 rstb[p]) else $error("read late");
      a_store_quiet: assert property (s_store |-> ##10 !rstb[p]) else $error("write strobed");
      a_wpar_odd: assert property ((req[p] && cyc == CYC_WR) || wstb[p] |->
         wpar[p] == ~^wdata[p]) else $error("even write parity");
   end
endmodule : cmp_bus_chk
`default_nettype wire

// ==== core_memory_port_control_tb.sv ====
// bench: four requesters and one memory unit facing each other on the bus
`timescale 1ns/1ns
`default_nettype none
module core_memory_port_control_tb;
   import cmp_pkg::*;
   logic                core_clk;
   logic                rst_b;
   logic [UNIT_W-1:0]   unit_sw;
   logic                ilv_en;
   logic                par_avail;
   logic                busy;
   logic                word_drive;
   logic [WORD_W-1:0]   digit_drive;
   logic [WORD_W-1:0]   dd_seen;
   logic [NPORT-1:0]    cmd_valid, cmd_ready, mod_valid, rsp_valid, rsp_par, par_ign, done;
   cmp_cyc_t            cmd_cyc [NPORT];
   logic [CYC_LSB-1:0]  cmd_addr [NPORT];
   logic [DATA_W-1:0]   cmd_wdata [NPORT], mod_data [NPORT], rsp_data [NPORT];
   int                  num_errors, num_checks, cyc_cnt, done_t [NPORT];
   cmp_bus_if bus ();
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   cmp_mem_unit cmp_mem_unit_i (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .unit_sw(unit_sw),
      .ilv_en(ilv_en), .par_avail(par_avail), .busy(busy), .word_drive(word_drive),
      .digit_drive(digit_drive));
   for (genvar p = 0; p < NPORT; p++) begin : g_rq
      cmp_requester #(.PORT(p)) cmp_requester_i (.core_clk(core_clk), .rst_b(rst_b), .bus(bus),
         .cmd_valid(cmd_valid[p]), .cmd_ready(cmd_ready[p]), .cmd_cyc(cmd_cyc[p]),
         .cmd_addr(cmd_addr[p]), .cmd_wdata(cmd_wdata[p]), .mod_valid(mod_valid[p]),
         .mod_data(mod_data[p]), .rsp_valid(rsp_valid[p]), .rsp_data(rsp_data[p]),
         .rsp_par(rsp_par[p]), .par_ign(par_ign[p]), .done(done[p]));
   end
   cmp_bus_chk cmp_bus_chk_i (.core_clk(core_clk), .rst_b(rst_b), .req(bus.req),
      .memory_address_lines(bus.memory_address_lines), .wdata(bus.wdata), .wpar(bus.wpar),
      .wstb(bus.wstb), .ack(bus.ack), .rstb(bus.rstb),
      .parity_ignore_pulse(bus.parity_ignore_pulse), .rdata(bus.rdata), .rpar(bus.rpar),
      .unit_sw(unit_sw), .ilv_en(ilv_en), .par_avail(par_avail));
   // ==========================================================
   // stack drive monitor and hang limit
   always @(negedge core_clk) begin
      cyc_cnt++;
      if (word_drive === 1'b1) dd_seen = digit_drive;
      if (cyc_cnt == 3000) begin
         num_errors++;
         final_report();
      end
   end
   // ==========================================================
   // helpers
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   task automatic chk_word(input string nm, input logic [36:0] e, input logic [36:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string nm, input logic e, input logic g);
      chk_word(nm, {36'h0, e}, {36'h0, g});
   endtask : chk_bit
   function automatic logic [21:0] ad(input logic [3:0] u, input logic [13:0] l);
      return {u, 4'h0, l};
   endfunction : ad
   task automatic do_reset();
      rst_b = 1'b0;
      cmd_valid = '0;
      repeat (12) @(posedge core_clk);
      #1 rst_b = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
   endtask : do_reset
   // one whole transaction; entered 1 ns after an edge with the port idle
   task automatic xfer(input int p, input cmp_cyc_t c, input logic [21:0] a,
      input logic [35:0] w, output logic [35:0] r, output logic pr, output logic pg,
      output logic ok);
      r = '0;
      pr = 1'b0;
      pg = 1'b0;
      ok = 1'b0;
      cmd_cyc[p] = c;
      cmd_addr[p] = a;
      cmd_wdata[p] = w;
      mod_data[p] = w;
      cmd_valid[p] = 1'b1;
      @(posedge core_clk);
      #1 cmd_valid[p] = 1'b0;
      for (int n = 0; n < 60 && !ok; n++) begin
         @(posedge core_clk);
         #1 mod_valid[p] = (rsp_valid[p] === 1'b1) && (c == CYC_RMW);
         if (par_ign[p] === 1'b1) pg = 1'b1;
         if (rsp_valid[p] === 1'b1) r = rsp_data[p];
         if (rsp_valid[p] === 1'b1) pr = rsp_par[p];
         ok = (done[p] === 1'b1);
      end
      done_t[p] = cyc_cnt;
   endtask : xfer
   task automatic wr_rd(input int p, input logic [21:0] a, input logic [35:0] d);
      logic [35:0] r;
      logic        pr, pg, ok;
      xfer(p, CYC_WR, a, d, r, pr, pg, ok);
      chk_bit("ready after done", 1'b1, cmd_ready[p]);
      xfer(p, CYC_RD, a, 36'h0, r, pr, pg, ok);
      chk_word("read word", {~^d, d}, {pr, r});
      chk_word("stack drive", {~^d, d}, dd_seen);
      xfer(p, CYC_RD, a, 36'h0, r, pr, pg, ok);
      chk_word("restored word", {~^d, d}, {pr, r});
   endtask : wr_rd
   // ==========================================================
   // scenarios
   task automatic t_ports();
      for (int p = 0; p < NPORT; p++) begin
         wr_rd(p, ad(4'h5, 14'h3FFF - 14'(p)), 36'hA_5A5A_5A50 + 36'(p));
      end
   endtask : t_ports
   task automatic t_priority();
      logic [35:0] r [3];
      logic        pr [3], pg [3], ok [3];
      fork
         xfer(2, CYC_WR, ad(4'h5, 14'h0010), 36'h2, r[2], pr[2], pg[2], ok[2]);
         xfer(1, CYC_WR, ad(4'h5, 14'h0011), 36'h1, r[1], pr[1], pg[1], ok[1]);
         xfer(0, CYC_WR, ad(4'h5, 14'h0012), 36'h0, r[0], pr[0], pg[0], ok[0]);
      join
      chk_bit("busy in cycle", 1'b1, busy);
      chk_word("spacing 0 to 1", 37'h12, 37'(done_t[1] - done_t[0]));
      chk_word("spacing 1 to 2", 37'h12, 37'(done_t[2] - done_t[1]));
   endtask : t_priority
   task automatic t_rmw();
      logic [35:0] r;
      logic        pr, pg, ok;
      xfer(1, CYC_WR, ad(4'h5, 14'h0020), 36'h1_2345_6789, r, pr, pg, ok);
      xfer(1, CYC_RMW, ad(4'h5, 14'h0020), 36'hF_EDCB_A986, r, pr, pg, ok);
      chk_word("rmw old", {~^36'h1_2345_6789, 36'h1_2345_6789}, {pr, r});
      xfer(1, CYC_RD, ad(4'h5, 14'h0020), 36'h0, r, pr, pg, ok);
      chk_word("rmw new", {~^36'hF_EDCB_A986, 36'hF_EDCB_A986}, {pr, r});
   endtask : t_rmw
   task automatic t_par_ign();
      logic [35:0] r;
      logic        pr, pg, ok;
      for (int i = 0; i < 2; i++) begin
         par_avail = i[0];
         xfer(2, CYC_WR, ad(4'h5, 14'h0030), 36'h7, r, pr, pg, ok);
         chk_bit("parity ignore", ~par_avail, pg);
      end
   endtask : t_par_ign
   // a foreign address hangs its requester, so a reset ends the scenario
   task automatic t_select(input logic ilv, input logic [21:0] hit, input logic [21:0] miss);
      logic [35:0] r;
      logic        pr, pg, ok;
      ilv_en = ilv;
      wr_rd(0, hit, 36'h5_0000_000F);
      xfer(3, CYC_WR, miss, 36'h1, r, pr, pg, ok);
      chk_bit("foreign unit answered", 1'b0, ok);
      chk_bit("busy for foreign unit", 1'b0, busy);
      xfer(2, CYC_NONE, hit, 36'h1, r, pr, pg, ok);
      chk_bit("type none answered", 1'b0, ok);
      do_reset();
      ilv_en = 1'b0;
   endtask : t_select
   // ==========================================================
   // main sequence
   initial begin
      unit_sw = 4'h5;
      ilv_en = 1'b0;
      par_avail = 1'b1;
      cyc_cnt = 0;
      num_errors = 0;
      num_checks = 0;
      mod_valid = '0;
      dd_seen = '0;
      for (int p = 0; p < NPORT; p++) begin
         cmd_cyc[p] = CYC_RD;
         cmd_addr[p] = '0;
         cmd_wdata[p] = '0;
         mod_data[p] = '0;
      end
      do_reset();
      t_ports();
      t_priority();
      t_rmw();
      t_par_ign();
      t_select(1'b0, ad(4'h5, 14'h0100), ad(4'h6, 14'h0100));
      t_select(1'b1, {3'h2, 1'b0, 4'h0, 14'h0101}, {3'h2, 1'b0, 4'h0, 14'h0100});
      final_report();
   end
endmodule : core_memory_port_control_tb
`default_nettype wire
